// file: common/acdt_pkg.sv
// Shared constants, register map and carrier types for the ramp time selector.
package acdt_pkg;
  localparam int CLK_HZ = 200_000_000;
  // One ramp step per tick; every stored time is counted in ticks of 0.1 s.
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES = (CLK_HZ / 1000) * TICK_MS;
  localparam int DW = 16;
  localparam int AW = 8;
  localparam int NREG = 23;
  localparam int IW = 5;
  // Stored code for the "disabled / fall back" setting.
  localparam logic [15:0] SENT = 16'hffff;
  localparam logic [15:0] ZERO = 16'h0000;
  localparam logic [15:0] ONE = 16'h0001;
  localparam logic [15:0] FMAX = 16'hffff;
  localparam logic [15:0] TIME_MAX = 16'h8ca0;
  localparam logic [15:0] FAIL_MAX = 16'h1964;
  localparam logic [15:0] SC_MIN = 16'h0001;
  localparam logic [15:0] SC_MAX = 16'h0019;
  localparam logic [15:0] T5S = 16'h0032;
  localparam logic [15:0] REF_RST = 16'h1770;
  localparam logic [15:0] REF_MAX = 16'h9c40;
  localparam logic [IW-1:0] IDX_CTRL = 5'h00;
  localparam logic [IW-1:0] IDX_STAT = 5'h01;
  localparam logic [IW-1:0] IDX_TGT = 5'h02;
  localparam logic [IW-1:0] IDX_REF = 5'h03;
  localparam logic [IW-1:0] IDX_B_ACC = 5'h04;
  localparam logic [IW-1:0] IDX_B_DEC = 5'h05;
  localparam logic [IW-1:0] IDX_B_SCA = 5'h06;
  localparam logic [IW-1:0] IDX_B_SCD = 5'h07;
  localparam logic [IW-1:0] IDX_T_ACC = 5'h08;
  localparam logic [IW-1:0] IDX_T_DEC = 5'h09;
  localparam logic [IW-1:0] IDX_T_SCA = 5'h0a;
  localparam logic [IW-1:0] IDX_T_SCD = 5'h0b;
  localparam logic [IW-1:0] IDX_S_ACC = 5'h0c;
  localparam logic [IW-1:0] IDX_S_DEC = 5'h0d;
  localparam logic [IW-1:0] IDX_S_SCA = 5'h0e;
  localparam logic [IW-1:0] IDX_S_SCD = 5'h0f;
  localparam logic [IW-1:0] IDX_F_DEC = 5'h10;
  localparam logic [IW-1:0] IDX_F_SC = 5'h11;
  localparam logic [IW-1:0] IDX_M_ACC = 5'h12;
  localparam logic [IW-1:0] IDX_M_DEC = 5'h13;
  localparam logic [IW-1:0] IDX_GAIN_A = 5'h14;
  localparam logic [IW-1:0] IDX_GAIN_B = 5'h15;
  localparam logic [IW-1:0] IDX_OUTF = 5'h16;
  localparam int CTRL_MASTER = 0;
  localparam int ST_RUN = 0;
  localparam int ST_PAT = 1;
  localparam int ST_SPD = 2;
  localparam int ST_FAIL = 3;
  // Per register: reset value, accepted range, whether the fallback code is accepted, writable.
  localparam logic [15:0] CFG_RST [NREG] = '{ZERO, ZERO, ZERO, REF_RST, T5S, T5S, SC_MIN, SC_MIN,
    T5S, SENT, SC_MIN, SC_MIN, SENT, SENT, SC_MIN, SC_MIN, SENT, SENT, T5S, T5S, ZERO, ZERO, ZERO};
  localparam logic [15:0] CFG_MIN [NREG] = '{ZERO, ZERO, ZERO, ONE, ZERO, ZERO, SC_MIN, SC_MIN,
    ZERO, ZERO, SC_MIN, SC_MIN, ZERO, ZERO, SC_MIN, SC_MIN, ZERO, SC_MIN, ZERO, ZERO, ZERO, ZERO, ZERO};
  localparam logic [15:0] CFG_MAX [NREG] = '{ONE, ZERO, FMAX, REF_MAX, TIME_MAX, TIME_MAX, SC_MAX, SC_MAX,
    TIME_MAX, TIME_MAX, SC_MAX, SC_MAX, TIME_MAX, TIME_MAX, SC_MAX, SC_MAX, FAIL_MAX, SC_MAX,
    TIME_MAX, TIME_MAX, FMAX, FMAX, ZERO};
  localparam logic [NREG-1:0] CFG_SENT_OK = 23'h033300;
  localparam logic [NREG-1:0] CFG_WR = 23'h3ffffd;

  typedef struct packed {
    logic [DW-1:0] acc;
    logic [DW-1:0] dec;
    logic [DW-1:0] sca;
    logic [DW-1:0] scd;
  } acdt_ramp_set_s;
endpackage

// file: rtl/acdt_slope.sv
// Converts a ramp time into a per-tick frequency step against the reference frequency.
`timescale 1ns/10ps
module acdt_slope (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [acdt_pkg::DW-1:0] ref_freq,
  input wire logic [acdt_pkg::DW-1:0] ramp_time,
  output logic [acdt_pkg::DW-1:0] slope
);
  logic [acdt_pkg::DW-1:0] slope_ff;
  logic [acdt_pkg::DW-1:0] nxt_slope;
  logic [acdt_pkg::DW-1:0] quot;

  // A zero time jumps in one tick; a step never rounds to zero so a ramp cannot stall.
  always_comb begin
    quot = acdt_pkg::ZERO;
    if (ramp_time != acdt_pkg::ZERO) begin
      quot = ref_freq / ramp_time;
    end
    nxt_slope = (ramp_time == acdt_pkg::ZERO) ? ref_freq : quot;
    if (nxt_slope == acdt_pkg::ZERO) begin
      nxt_slope = acdt_pkg::ONE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      slope_ff <= acdt_pkg::ONE;
    end else begin
      slope_ff <= nxt_slope;
    end
  end

  assign slope = slope_ff;

  AST_SLOPE_RATIO: assert property (@(posedge core_clk) disable iff (reset)
    (ramp_time != acdt_pkg::ZERO && ref_freq >= ramp_time) |=>
    (32'(slope_ff) * 32'($past(ramp_time)) <= 32'($past(ref_freq)))
    && (32'(slope_ff + acdt_pkg::ONE) * 32'($past(ramp_time)) > 32'($past(ref_freq))))
    else $error("Ramp step does not match reference over time.");
endmodule // acdt_slope

// file: rtl/acdt_ramp.sv
// Steps the output frequency once per tick toward the target, saturating at it.
`timescale 1ns/10ps
module acdt_ramp #(
  parameter int TICK_CYCLES = acdt_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [acdt_pkg::DW-1:0] target,
  input wire logic [acdt_pkg::DW-1:0] up_step,
  input wire logic [acdt_pkg::DW-1:0] dn_step,
  output logic [acdt_pkg::DW-1:0] out_freq
);
  logic [31:0] tick_cnt_ff;
  logic [31:0] nxt_tick_cnt;
  logic [acdt_pkg::DW-1:0] out_ff;
  logic [acdt_pkg::DW-1:0] nxt_out;
  logic tick;

  always_comb begin
    tick = (tick_cnt_ff == 32'(TICK_CYCLES - 1));
    nxt_tick_cnt = tick ? 32'h0000_0000 : tick_cnt_ff + 32'h0000_0001;
    nxt_out = out_ff;
    if (tick && out_ff < target) begin
      nxt_out = ((target - out_ff) > up_step) ? out_ff + up_step : target;
    end else if (tick && out_ff > target) begin
      nxt_out = ((out_ff - target) > dn_step) ? out_ff - dn_step : target;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      tick_cnt_ff <= 32'h0000_0000;
      out_ff <= acdt_pkg::ZERO;
    end else begin
      tick_cnt_ff <= nxt_tick_cnt;
      out_ff <= nxt_out;
    end
  end

  assign out_freq = out_ff;

  AST_RAMP_NO_OVERSHOOT: assert property (@(posedge core_clk) disable iff (reset)
    (out_ff <= target) |=> (out_ff <= $past(target)))
    else $error("Rising ramp passed its target.");
  AST_RAMP_STEP_SIZE: assert property (@(posedge core_clk) disable iff (reset)
    (out_ff < target && tick) |=> (out_ff == $past(out_ff) + $past(up_step) || out_ff == $past(target)))
    else $error("Rising ramp step differs from slope.");
endmodule // acdt_ramp

// file: rtl/acdt_top.sv
// Ramp time selector with Wishbone register file and ramp generator.
//
// Design decisions made here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/10ps
module acdt_top #(
  parameter int TICK_CYCLES = acdt_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [acdt_pkg::AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ramp_pattern_select,
  input wire logic feed_mode_select,
  input wire logic feed_mode_assigned,
  input wire logic system_failure,
  output acdt_pkg::acdt_ramp_set_s active_set,
  output logic [acdt_pkg::DW-1:0] out_freq,
  output logic drive_running
);
  logic [acdt_pkg::DW-1:0] cfg_ff [acdt_pkg::NREG];
  logic [acdt_pkg::DW-1:0] nxt_cfg [acdt_pkg::NREG];
  logic ack_ff;
  logic nxt_ack;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic pat_ff;
  logic nxt_pat;
  logic run_ff;
  logic nxt_run;
  acdt_pkg::acdt_ramp_set_s sel_ff;
  acdt_pkg::acdt_ramp_set_s nxt_sel;
  acdt_pkg::acdt_ramp_set_s norm;
  logic [acdt_pkg::DW-1:0] ramp_out;
  logic [acdt_pkg::DW-1:0] up_step;
  logic [acdt_pkg::DW-1:0] dn_step;
  logic [acdt_pkg::DW-1:0] ramp_tgt;
  logic [acdt_pkg::IW-1:0] idx;
  logic wr_req;
  logic mst;
  logic spd;
  logic [3:0] status;

  assign idx = wb_adr_i[6:2];
  // A write lands on the edge at which the master samples ack high.
  assign wr_req = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff && !wb_adr_i[acdt_pkg::AW-1];

  // Each writable setting merges byte lanes and keeps its old value on an out-of-range write.
  genvar gi;
  generate
    for (gi = 0; gi < acdt_pkg::NREG; gi = gi + 1) begin : g_cfg
      logic [acdt_pkg::DW-1:0] merged;
      logic in_range;
      always_comb begin
        merged[7:0] = wb_sel_i[0] ? wb_dat_i[7:0] : cfg_ff[gi][7:0];
        merged[15:8] = wb_sel_i[1] ? wb_dat_i[15:8] : cfg_ff[gi][15:8];
        in_range = (merged >= acdt_pkg::CFG_MIN[gi] && merged <= acdt_pkg::CFG_MAX[gi])
          || (acdt_pkg::CFG_SENT_OK[gi] && merged == acdt_pkg::SENT);
        nxt_cfg[gi] = cfg_ff[gi];
        if (wr_req && acdt_pkg::CFG_WR[gi] && idx == acdt_pkg::IW'(gi) && in_range) begin
          nxt_cfg[gi] = merged;
        end
      end
      always_ff @(posedge core_clk) begin
        if (reset) begin
          cfg_ff[gi] <= acdt_pkg::CFG_RST[gi];
        end else begin
          cfg_ff[gi] <= nxt_cfg[gi];
        end
      end
    end
  endgenerate

  // Bus answer: one-cycle ack after every request, zero data for unmapped offsets.
  always_comb begin
    nxt_ack = wb_cyc_i && wb_stb_i && !ack_ff;
    nxt_rdata = 32'h0000_0000;
    if (wb_adr_i[acdt_pkg::AW-1]) begin
      nxt_rdata = 32'h0000_0000;
    end else if (idx == acdt_pkg::IDX_STAT) begin
      nxt_rdata = 32'(status);
    end else if (idx == acdt_pkg::IDX_OUTF) begin
      nxt_rdata = 32'(ramp_out);
    end else if (idx < acdt_pkg::IW'(acdt_pkg::NREG)) begin
      nxt_rdata = 32'(cfg_ff[idx]);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end

  // Time set selection.
  assign mst = cfg_ff[acdt_pkg::IDX_CTRL][acdt_pkg::CTRL_MASTER];
  assign spd = feed_mode_assigned && feed_mode_select
    && cfg_ff[acdt_pkg::IDX_S_ACC] != acdt_pkg::SENT;
  assign status = {system_failure, spd, pat_ff, run_ff};

  always_comb begin
    nxt_run = (ramp_out != acdt_pkg::ZERO);
    nxt_pat = run_ff ? pat_ff : ramp_pattern_select;
    norm.acc = cfg_ff[acdt_pkg::IDX_B_ACC];
    norm.dec = cfg_ff[acdt_pkg::IDX_B_DEC];
    norm.sca = cfg_ff[acdt_pkg::IDX_B_SCA];
    norm.scd = cfg_ff[acdt_pkg::IDX_B_SCD];
    if (spd) begin
      norm.acc = cfg_ff[acdt_pkg::IDX_S_ACC];
      norm.dec = (cfg_ff[acdt_pkg::IDX_S_DEC] == acdt_pkg::SENT) ?
        cfg_ff[acdt_pkg::IDX_S_ACC] : cfg_ff[acdt_pkg::IDX_S_DEC];
      norm.sca = cfg_ff[acdt_pkg::IDX_S_SCA];
      norm.scd = cfg_ff[acdt_pkg::IDX_S_SCD];
    end else if (pat_ff && cfg_ff[acdt_pkg::IDX_T_ACC] != acdt_pkg::SENT) begin
      norm.acc = cfg_ff[acdt_pkg::IDX_T_ACC];
      norm.dec = (cfg_ff[acdt_pkg::IDX_T_DEC] == acdt_pkg::SENT) ?
        cfg_ff[acdt_pkg::IDX_T_ACC] : cfg_ff[acdt_pkg::IDX_T_DEC];
      norm.sca = cfg_ff[acdt_pkg::IDX_T_SCA];
      norm.scd = cfg_ff[acdt_pkg::IDX_T_SCD];
    end
    if (mst) begin
      norm.acc = cfg_ff[acdt_pkg::IDX_M_ACC];
      norm.dec = cfg_ff[acdt_pkg::IDX_M_DEC];
    end
    nxt_sel = norm;
    if (system_failure && cfg_ff[acdt_pkg::IDX_F_DEC] != acdt_pkg::SENT) begin
      nxt_sel.dec = cfg_ff[acdt_pkg::IDX_F_DEC];
    end
    if (system_failure && cfg_ff[acdt_pkg::IDX_F_SC] != acdt_pkg::SENT) begin
      nxt_sel.scd = cfg_ff[acdt_pkg::IDX_F_SC];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      run_ff <= 1'b0;
      pat_ff <= 1'b0;
      sel_ff <= '{acc: acdt_pkg::T5S, dec: acdt_pkg::T5S, sca: acdt_pkg::SC_MIN, scd: acdt_pkg::SC_MIN};
    end else begin
      run_ff <= nxt_run;
      pat_ff <= nxt_pat;
      sel_ff <= nxt_sel;
    end
  end

  // A failure brings the drive down to stop with the failure deceleration.
  assign ramp_tgt = system_failure ? acdt_pkg::ZERO : cfg_ff[acdt_pkg::IDX_TGT];

  acdt_slope u_up_slope (
    .core_clk(core_clk),
    .reset(reset),
    .ref_freq(cfg_ff[acdt_pkg::IDX_REF]),
    .ramp_time(sel_ff.acc),
    .slope(up_step)
  );

  acdt_slope u_dn_slope (
    .core_clk(core_clk),
    .reset(reset),
    .ref_freq(cfg_ff[acdt_pkg::IDX_REF]),
    .ramp_time(sel_ff.dec),
    .slope(dn_step)
  );

  acdt_ramp #(.TICK_CYCLES(TICK_CYCLES)) u_ramp (
    .core_clk(core_clk),
    .reset(reset),
    .target(ramp_tgt),
    .up_step(up_step),
    .dn_step(dn_step),
    .out_freq(ramp_out)
  );

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;
  assign active_set = sel_ff;
  assign out_freq = ramp_out;
  assign drive_running = run_ff;

  AST_PATTERN_HOLD: assert property (@(posedge core_clk) disable iff (reset)
    run_ff |=> $stable(pat_ff))
    else $error("Pattern selection changed while running.");
  AST_BASE_SET: assert property (@(posedge core_clk) disable iff (reset)
    (!mst && !spd && !pat_ff && !system_failure) |=>
    (sel_ff.acc == $past(cfg_ff[acdt_pkg::IDX_B_ACC]) && sel_ff.dec == $past(cfg_ff[acdt_pkg::IDX_B_DEC])))
    else $error("Base set not selected.");
  AST_THIRD_DEC: assert property (@(posedge core_clk) disable iff (reset)
    (!mst && !spd && pat_ff && !system_failure && cfg_ff[acdt_pkg::IDX_T_ACC] != acdt_pkg::SENT
    && cfg_ff[acdt_pkg::IDX_T_DEC] == acdt_pkg::SENT) |=> sel_ff.dec == $past(cfg_ff[acdt_pkg::IDX_T_ACC]))
    else $error("Third decel fallback wrong.");
  AST_MASTER_WINS: assert property (@(posedge core_clk) disable iff (reset)
    mst |=> sel_ff.acc == $past(cfg_ff[acdt_pkg::IDX_M_ACC]))
    else $error("Master acceleration time not used.");
  AST_SPEED_SET: assert property (@(posedge core_clk) disable iff (reset)
    (spd && !mst) |=> (sel_ff.acc == $past(cfg_ff[acdt_pkg::IDX_S_ACC])
    && sel_ff.sca == $past(cfg_ff[acdt_pkg::IDX_S_SCA])))
    else $error("Speed feed set not used.");
  AST_SPEED_OFF: assert property (@(posedge core_clk) disable iff (reset)
    (cfg_ff[acdt_pkg::IDX_S_ACC] == acdt_pkg::SENT || !feed_mode_assigned) |-> !spd)
    else $error("Speed feed active while disabled.");
  AST_SPEED_DEC: assert property (@(posedge core_clk) disable iff (reset)
    (spd && !mst && !system_failure && cfg_ff[acdt_pkg::IDX_S_DEC] == acdt_pkg::SENT) |=>
    sel_ff.dec == $past(cfg_ff[acdt_pkg::IDX_S_ACC]))
    else $error("Speed feed decel fallback wrong.");
  AST_FAIL_DEC: assert property (@(posedge core_clk) disable iff (reset)
    system_failure |=> sel_ff.dec == (($past(cfg_ff[acdt_pkg::IDX_F_DEC]) == acdt_pkg::SENT) ?
    $past(norm.dec) : $past(cfg_ff[acdt_pkg::IDX_F_DEC])))
    else $error("Failure deceleration time wrong.");
  AST_FAIL_SC: assert property (@(posedge core_clk) disable iff (reset)
    system_failure |=> sel_ff.scd == (($past(cfg_ff[acdt_pkg::IDX_F_SC]) == acdt_pkg::SENT) ?
    $past(norm.scd) : $past(cfg_ff[acdt_pkg::IDX_F_SC])))
    else $error("Failure S-curve time wrong.");
  AST_GAIN_KEEP: assert property (@(posedge core_clk) disable iff (reset)
    (wr_req && idx == acdt_pkg::IDX_REF) |=>
    ($stable(cfg_ff[acdt_pkg::IDX_GAIN_A]) && $stable(cfg_ff[acdt_pkg::IDX_GAIN_B])))
    else $error("Gain changed by reference write.");
  AST_SCURVE_RANGE: assert property (@(posedge core_clk) disable iff (reset)
    cfg_ff[acdt_pkg::IDX_T_SCA] >= acdt_pkg::SC_MIN && cfg_ff[acdt_pkg::IDX_T_SCA] <= acdt_pkg::SC_MAX)
    else $error("Third S-curve accel out of range.");
  AST_THIRD_SET: assert property (@(posedge core_clk) disable iff (reset)
    (!mst && !spd && pat_ff && !system_failure && cfg_ff[acdt_pkg::IDX_T_ACC] != acdt_pkg::SENT) |=>
    (sel_ff.acc == $past(cfg_ff[acdt_pkg::IDX_T_ACC]) && sel_ff.sca == $past(cfg_ff[acdt_pkg::IDX_T_SCA])
    && sel_ff.scd == $past(cfg_ff[acdt_pkg::IDX_T_SCD])))
    else $error("Third set not selected.");
  AST_THIRD_OFF: assert property (@(posedge core_clk) disable iff (reset)
    (!mst && !spd && !system_failure && cfg_ff[acdt_pkg::IDX_T_ACC] == acdt_pkg::SENT) |=>
    sel_ff.acc == $past(cfg_ff[acdt_pkg::IDX_B_ACC]))
    else $error("Base accel not used with third set off.");
  AST_BASE_SCURVE: assert property (@(posedge core_clk) disable iff (reset)
    (!spd && !pat_ff && !system_failure) |=>
    (sel_ff.sca == $past(cfg_ff[acdt_pkg::IDX_B_SCA]) && sel_ff.scd == $past(cfg_ff[acdt_pkg::IDX_B_SCD])))
    else $error("Base S-curve times not used.");
  AST_PATTERN_LATCH: assert property (@(posedge core_clk) disable iff (reset)
    !run_ff |=> pat_ff == $past(ramp_pattern_select))
    else $error("Pattern input not taken while stopped.");
  AST_RUN_FLAG: assert property (@(posedge core_clk) disable iff (reset)
    (ramp_out != acdt_pkg::ZERO) |=> run_ff)
    else $error("Running flag low while output moves.");
  AST_MASTER_DEC: assert property (@(posedge core_clk) disable iff (reset)
    (mst && !system_failure) |=> sel_ff.dec == $past(cfg_ff[acdt_pkg::IDX_M_DEC]))
    else $error("Master decel time not used.");
  AST_SPEED_SCD: assert property (@(posedge core_clk) disable iff (reset)
    (spd && !system_failure) |=> sel_ff.scd == $past(cfg_ff[acdt_pkg::IDX_S_SCD]))
    else $error("Speed feed S-curve decel not used.");
  AST_POSITION_FEED: assert property (@(posedge core_clk) disable iff (reset)
    !feed_mode_select |-> !spd)
    else $error("Speed feed with feed input off.");
  AST_FAIL_TARGET: assert property (@(posedge core_clk) disable iff (reset)
    system_failure |-> ramp_tgt == acdt_pkg::ZERO)
    else $error("Failure target is not stop.");

  // Stored settings hold only their accepted range or, where allowed, the fallback code.
  AST_SPEED_ACC_RANGE: assert property (@(posedge core_clk) disable iff (reset)
    cfg_ff[acdt_pkg::IDX_S_ACC] <= acdt_pkg::TIME_MAX || cfg_ff[acdt_pkg::IDX_S_ACC] == acdt_pkg::SENT)
    else $error("Speed accel out of range.");
  AST_SPEED_DEC_RANGE: assert property (@(posedge core_clk) disable iff (reset)
    cfg_ff[acdt_pkg::IDX_S_DEC] <= acdt_pkg::TIME_MAX || cfg_ff[acdt_pkg::IDX_S_DEC] == acdt_pkg::SENT)
    else $error("Speed decel out of range.");
  AST_FAIL_DEC_RANGE: assert property (@(posedge core_clk) disable iff (reset)
    cfg_ff[acdt_pkg::IDX_F_DEC] <= acdt_pkg::FAIL_MAX || cfg_ff[acdt_pkg::IDX_F_DEC] == acdt_pkg::SENT)
    else $error("Failure decel out of range.");
  AST_FAIL_SC_RANGE: assert property (@(posedge core_clk) disable iff (reset)
    (cfg_ff[acdt_pkg::IDX_F_SC] >= acdt_pkg::SC_MIN && cfg_ff[acdt_pkg::IDX_F_SC] <= acdt_pkg::SC_MAX)
    || cfg_ff[acdt_pkg::IDX_F_SC] == acdt_pkg::SENT)
    else $error("Failure S-curve out of range.");
  AST_THIRD_SCD_RANGE: assert property (@(posedge core_clk) disable iff (reset)
    cfg_ff[acdt_pkg::IDX_T_SCD] >= acdt_pkg::SC_MIN && cfg_ff[acdt_pkg::IDX_T_SCD] <= acdt_pkg::SC_MAX)
    else $error("Third S-curve decel out of range.");
  AST_SPEED_SCA_RANGE: assert property (@(posedge core_clk) disable iff (reset)
    cfg_ff[acdt_pkg::IDX_S_SCA] >= acdt_pkg::SC_MIN && cfg_ff[acdt_pkg::IDX_S_SCA] <= acdt_pkg::SC_MAX)
    else $error("Speed S-curve accel out of range.");
  AST_SPEED_SCD_RANGE: assert property (@(posedge core_clk) disable iff (reset)
    cfg_ff[acdt_pkg::IDX_S_SCD] >= acdt_pkg::SC_MIN && cfg_ff[acdt_pkg::IDX_S_SCD] <= acdt_pkg::SC_MAX)
    else $error("Speed S-curve decel out of range.");
  AST_REF_RANGE: assert property (@(posedge core_clk) disable iff (reset)
    cfg_ff[acdt_pkg::IDX_REF] >= acdt_pkg::ONE && cfg_ff[acdt_pkg::IDX_REF] <= acdt_pkg::REF_MAX)
    else $error("Reference frequency out of range.");
  CVR_THIRD_RUN: cover property (@(posedge core_clk) disable iff (reset) pat_ff && run_ff);
  CVR_PATTERN_DEFER: cover property (@(posedge core_clk) disable iff (reset) run_ff && ramp_pattern_select && !pat_ff);
  CVR_MASTER: cover property (@(posedge core_clk) disable iff (reset) mst && run_ff);
  CVR_SPEED: cover property (@(posedge core_clk) disable iff (reset) spd && run_ff);
  CVR_FAIL_STOP: cover property (@(posedge core_clk) disable iff (reset) system_failure ##1 !run_ff);
endmodule // acdt_top

// file: test/acdt_host.sv
// Host master and input terminal model that drives the selector's bus and pins.
`timescale 1ns/10ps
module acdt_host (
  input wire logic core_clk,
  output logic wb_cyc,
  output logic wb_stb,
  output logic wb_we,
  output logic [7:0] wb_adr,
  output logic [3:0] wb_sel,
  output logic [31:0] wb_dat,
  input wire logic wb_ack,
  input wire logic [31:0] wb_rdat,
  output logic pat,
  output logic feed,
  output logic assigned,
  output logic fail
);
  initial begin
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} = '0;
    {pat, feed, assigned, fail} = 4'h0;
  end
  // One classic cycle; the request holds until ack is seen at a rising edge.
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wdat, output logic [31:0] rdat);
    rdat = '1;
    @(posedge core_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= 4'h3;
    wb_dat <= wdat;
    do begin
      @(posedge core_clk);
    end while (wb_ack !== 1'b1);
    rdat = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_dat <= ~wdat;
    @(posedge core_clk);
  endtask
  // The feed mode pin is driven whatever assigned is; the selector only uses its level once its terminal function is assigned.
  task automatic term(input logic p, input logic f, input logic a, input logic s);
    @(posedge core_clk);
    pat <= p;
    feed <= f;
    assigned <= a;
    fail <= s;
  endtask
endmodule // acdt_host

// file: test/accel_decel_time_selector_test.sv
// Self-checking bench for the ramp time selector.
`timescale 1ns/10ps
module accel_decel_time_selector_test;
  localparam int TICKS = 8;
  logic core_clk, reset, cyc, stb, we, pat, feed, asg, fail, ack, running;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic [15:0] out_freq;
  acdt_pkg::acdt_ramp_set_s active_set;
  int err_count, n_checks;
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  acdt_host host (.core_clk(core_clk), .wb_cyc(cyc), .wb_stb(stb), .wb_we(we), .wb_adr(adr), .wb_sel(sel),
    .wb_dat(wdat), .wb_ack(ack), .wb_rdat(rdat), .pat(pat), .feed(feed), .assigned(asg), .fail(fail));
  acdt_top #(.TICK_CYCLES(TICKS)) dut (.core_clk(core_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ramp_pattern_select(pat), .feed_mode_select(feed), .feed_mode_assigned(asg), .system_failure(fail),
    .active_set(active_set), .out_freq(out_freq), .drive_running(running));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic chk_set(input logic [15:0] a, input logic [15:0] d, input logic [15:0] sa, input logic [15:0] sd);
    chk(active_set.acc, a, "acc");
    chk(active_set.dec, d, "dec");
    chk(active_set.sca, sa, "s acc");
    chk(active_set.scd, sd, "s dec");
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    logic [31:0] r;
    host.xfer(1'b1, a, {16'h0000, v}, r);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    logic [31:0] r;
    host.xfer(1'b0, a, 32'h0000_0000, r);
    chk(r[15:0], exp, "read");
    chk(r[31:16], 16'h0000, "read upper");
  endtask
  task automatic settle();
    repeat (3) @(posedge core_clk);
  endtask
  task automatic wait_freq(input logic [15:0] v, input logic until_eq);
    int n;
    for (n = 0; n < 40 * TICKS && ((out_freq === v) != until_eq); n++) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic t_reset();
    chk_set(16'h0032, 16'h0032, 16'h0001, 16'h0001);
    rd_chk(8'h0c, 16'h1770);
    rd_chk(8'h2c, 16'h0001);
    rd_chk(8'h30, 16'hffff);
    rd_chk(8'h34, 16'hffff);
    rd_chk(8'h3c, 16'h0001);
    $display("done reset");
  endtask
  task automatic t_pattern();
    wr(8'h20, 16'h0064);
    wr(8'h28, 16'h0003);
    wr(8'h2c, 16'h0004);
    wr(8'h28, 16'h001a);
    rd_chk(8'h28, 16'h0003);
    host.term(1'b1, 1'b0, 1'b0, 1'b0);
    settle();
    chk_set(16'h0064, 16'h0064, 16'h0003, 16'h0004);
    host.term(1'b0, 1'b0, 1'b0, 1'b0);
    settle();
    chk_set(16'h0032, 16'h0032, 16'h0001, 16'h0001);
    $display("done pattern");
  endtask
  task automatic t_ramp();
    wr(8'h08, 16'h028a);
    wait_freq(16'h0000, 1'b0);
    chk(out_freq, 16'h0078, "first up step");
    chk({15'h0000, running}, 16'h0001, "running");
    host.term(1'b1, 1'b0, 1'b0, 1'b0);
    settle();
    chk(active_set.acc, 16'h0032, "held while running");
    wait_freq(16'h028a, 1'b1);
    repeat (3 * TICKS) @(posedge core_clk);
    chk(out_freq, 16'h028a, "saturated");
    wr(8'h08, 16'h0000);
    wait_freq(16'h028a, 1'b0);
    chk(out_freq, 16'h0212, "first down step");
    wait_freq(16'h0000, 1'b1);
    settle();
    chk_set(16'h0064, 16'h0064, 16'h0003, 16'h0004);
    chk({15'h0000, running}, 16'h0000, "stopped");
    $display("done ramp");
  endtask
  task automatic t_speed();
    wr(8'h38, 16'h0005);
    wr(8'h3c, 16'h0006);
    host.term(1'b1, 1'b1, 1'b1, 1'b0);
    settle();
    chk_set(16'h0064, 16'h0064, 16'h0003, 16'h0004);
    wr(8'h30, 16'h00c8);
    wr(8'h30, 16'h8ca1);
    rd_chk(8'h30, 16'h00c8);
    settle();
    chk_set(16'h00c8, 16'h00c8, 16'h0005, 16'h0006);
    host.term(1'b1, 1'b1, 1'b0, 1'b0);
    settle();
    chk_set(16'h0064, 16'h0064, 16'h0003, 16'h0004);
    $display("done speed");
  endtask
  task automatic t_fail();
    wr(8'h40, 16'h001e);
    wr(8'h44, 16'h0002);
    host.term(1'b0, 1'b0, 1'b1, 1'b1);
    settle();
    chk(active_set.dec, 16'h001e, "failure dec");
    chk(active_set.scd, 16'h0002, "failure s dec");
    wr(8'h40, 16'h1965);
    rd_chk(8'h40, 16'h001e);
    wr(8'h40, 16'hffff);
    wr(8'h44, 16'hffff);
    host.term(1'b1, 1'b0, 1'b1, 1'b1);
    settle();
    chk(active_set.dec, 16'h0064, "fallback dec");
    chk(active_set.scd, 16'h0004, "fallback s dec");
    $display("done failure");
  endtask
  task automatic t_master();
    wr(8'h48, 16'h0046);
    wr(8'h4c, 16'h0050);
    wr(8'h00, 16'h0001);
    host.term(1'b1, 1'b0, 1'b1, 1'b0);
    settle();
    chk_set(16'h0046, 16'h0050, 16'h0003, 16'h0004);
    wr(8'h00, 16'h0000);
    host.term(1'b0, 1'b0, 1'b1, 1'b0);
    settle();
    chk_set(16'h0032, 16'h0032, 16'h0001, 16'h0001);
    wr(8'h20, 16'hffff);
    host.term(1'b1, 1'b0, 1'b1, 1'b0);
    settle();
    chk_set(16'h0032, 16'h0032, 16'h0001, 16'h0001);
    $display("done master");
  endtask
  task automatic t_regs();
    wr(8'h50, 16'h1234);
    wr(8'h0c, 16'h2ee0);
    rd_chk(8'h50, 16'h1234);
    rd_chk(8'h0c, 16'h2ee0);
    rd_chk(8'h80, 16'h0000);
    wr(8'h04, 16'h000f);
    rd_chk(8'h04, 16'h0002);
    wr(8'h08, 16'h0200);
    wait_freq(16'h0000, 1'b0);
    chk(out_freq, 16'h00f0, "scaled step");
    rd_chk(8'h58, 16'h00f0);
    wr(8'h08, 16'h0000);
    wait_freq(16'h0000, 1'b1);
    $display("done registers");
  endtask
  initial begin
    err_count = 0;
    n_checks = 0;
    reset = 1'b1;
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_pattern();
    t_ramp();
    t_speed();
    t_fail();
    t_master();
    t_regs();
    conclude();
  end
  initial begin
    #(5ns * 40000);
    err_count++;
    conclude();
  end
endmodule // accel_decel_time_selector_test
